//--- bench/tmr_rear_if_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// rear output checker
module tmr_rear_if_assertions
    import tmr_pkg::*;
#(
    parameter int DATA_GOOD_CYC = TMR_DATA_GOOD_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] low_digit_group_o,
    input wire logic [3:0] high_digit_group_o,
    input wire logic rate_slow_o,
    input wire logic data_good_o,
    input wire logic clk_out_o
);
    logic [31:0] dg_cnt_q;
    logic [7:0] ck_cnt_q;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // high-time counters
    always_ff @(posedge mclk_i) begin
        dg_cnt_q <= (sys_rst_i || !data_good_o) ? 32'h0 : dg_cnt_q + 32'h1;
        ck_cnt_q <= (sys_rst_i || !clk_out_o) ? 8'h0 : ck_cnt_q + 8'h1;
    end
    sequence s_digit_end;
        $fell(data_good_o) && $past(high_digit_group_o) < 4'h3;
    endsequence
    sequence s_next_digit;
        high_digit_group_o == $past(high_digit_group_o) + 4'h1 ##1 data_good_o;
    endsequence
    AST_NEXT_DIGIT: assert property (s_digit_end |-> s_next_digit)
        else $error("next digit not presented after gap");
    AST_DIGIT_ORDER: assert property ($rose(data_good_o) |->
        high_digit_group_o == 4'h0 || high_digit_group_o == $past(high_digit_group_o, 2) + 4'h1)
        else $error("strobe without digit update");
    AST_BCD_RANGE: assert property (data_good_o |->
        low_digit_group_o <= 4'h9 && high_digit_group_o <= 4'h3)
        else $error("digit lines out of range");
    AST_DIG_STABLE: assert property (data_good_o |->
        $stable(low_digit_group_o) && $stable(high_digit_group_o))
        else $error("digit changed under strobe");
    AST_RATE_HOLD: assert property (data_good_o |-> $stable(rate_slow_o))
        else $error("rate line changed under strobe");
    AST_DG_WIDTH: assert property ($fell(data_good_o) |-> dg_cnt_q == DATA_GOOD_CYC)
        else $error("strobe width wrong");
    AST_DG_MAX: assert property (data_good_o |-> dg_cnt_q < DATA_GOOD_CYC)
        else $error("strobe too long");
    AST_CLK_OUT_WIDTH: assert property ($fell(clk_out_o) |-> ck_cnt_q == TMR_CLK_OUT_HIGH_CYC)
        else $error("clock out high time wrong");
endmodule : tmr_rear_if_assertions
bind tmr_rear_if tmr_rear_if_assertions #(.DATA_GOOD_CYC(DATA_GOOD_CYC)) tmr_rear_if_assertions_inst (
    .mclk_i, .sys_rst_i, .low_digit_group_o, .high_digit_group_o, .rate_slow_o, .data_good_o, .clk_out_o);
`default_nettype wire

//--- bench/tmr_rear_if_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_rear_if_tb
    import tmr_pkg::*;
;
    localparam int DGC = 20;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] ref_mhz = 4'h0;
    logic [3:0] mhz_tab [4] = '{4'h0, 4'h1, 4'h5, 4'ha};
    logic hready, hresp, ext_ref, rate_slow, data_good, clk_out, marker;
    logic [31:0] hrdata;
    logic [3:0] low_dg, high_dg;
    int failures = 0;
    int tests_run = 0;
    int ck_rises = 0;
    int mk_rises = 0;

    always #5 mclk_i = ~mclk_i;
    always @(posedge clk_out) ck_rises++;
    always @(posedge marker) mk_rises++;

    tmr_rear_if #(.DATA_GOOD_CYC(DGC)) tmr_rear_if_inst (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
        .hresp_o(hresp), .hrdata_o(hrdata), .ext_ref_i(ext_ref), .low_digit_group_o(low_dg),
        .high_digit_group_o(high_dg), .rate_slow_o(rate_slow), .data_good_o(data_good),
        .clk_out_o(clk_out), .marker_o(marker));

    tmr_rear_partner tmr_rear_partner_inst (
        .ref_mhz_i(ref_mhz), .low_digit_group_i(low_dg), .high_digit_group_i(high_dg),
        .rate_slow_i(rate_slow), .data_good_i(data_good), .ext_ref_o(ext_ref));

    // ==========================================================
    // bus tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge mclk_i);
        while (hready !== 1'b1) @(posedge mclk_i);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge mclk_i);
        while (hready !== 1'b1) @(posedge mclk_i);
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        ahb(1'b1, a, d, rd);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask : rdchk

    function automatic logic [31:0] entry(input int e);
        logic [31:0] w;
        w = {15'h0, e[0], 16'h0};
        for (int k = 0; k < 4; k++) w[4*k +: 4] = 4'((e + k) % 10);
        return w;
    endfunction : entry

    task automatic report_and_stop();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // tests
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end

    initial begin
        time t0;
        logic [31:0] r, w;
        repeat (10) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        check(32'({hresp, low_dg, high_dg, rate_slow, data_good, clk_out, marker}), 32'h0);
        rdchk(TMR_REG_CTRL, 32'h0);
        rdchk(TMR_REG_STAT, 32'h1);
        rdchk(TMR_REG_DATA, 32'h0);
        rdchk(8'h0c, 32'h0);
        repeat (200) @(posedge mclk_i);
        check(32'(ck_rises), 32'h0);
        wr(TMR_REG_CTRL, 32'hffff_f5ea);
        rdchk(TMR_REG_CTRL, 32'h0000_050a);
        wr(8'h0c, 32'hffff_ffff);
        wr(TMR_REG_STAT, 32'hffff_ffff);
        rdchk(TMR_REG_STAT, 32'h1);
        rdchk(8'h0c, 32'h0);
        // internal, then 1, 5 and 10 mhz reference
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_out);
            ref_mhz <= mhz_tab[i];
            wr(TMR_REG_CTRL, (i == 0) ? 32'h8 : (32'h9 | (32'(i - 1) << 1)));
            @(posedge clk_out);
            @(posedge clk_out);
            t0 = $time;
            @(posedge clk_out);
            check(32'($time - t0), 32'd1000);
        end
        for (int e = 0; e < 9; e++) wr(TMR_REG_DATA, entry(e));
        ahb(1'b0, TMR_REG_STAT, 32'h0, r);
        check(r & 32'h0000_0f06, 32'h0000_0806);
        t0 = $time;
        wr(TMR_REG_DATA, entry(9));
        check(32'(($time - t0) > 200), 32'h1);
        while (tmr_rear_partner_inst.got_q.size() < 40) @(posedge mclk_i);
        repeat (DGC + 5) @(posedge mclk_i);
        for (int n = 0; n < 40; n++) begin
            w = entry(n / 4);
            check(32'(tmr_rear_partner_inst.got_q[n]), {23'h0, w[16], 4'(n % 4), w[4*(n%4) +: 4]});
        end
        ahb(1'b0, TMR_REG_STAT, 32'h0, r);
        check(r & 32'h0000_0f07, 32'h1);
        // marker on at 2 ms interval: no pulse within the first ten ticks
        @(negedge clk_out);
        wr(TMR_REG_CTRL, 32'h0000_0a18);
        rdchk(TMR_REG_CTRL, 32'h0000_0a18);
        repeat (1000) @(posedge mclk_i);
        check(32'(mk_rises), 32'h0);
        report_and_stop();
    end
endmodule : tmr_rear_if_tb
`default_nettype wire

//--- bench/tmr_rear_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far-side decoder: reference source and digit capture
module tmr_rear_partner (
    input wire logic [3:0] ref_mhz_i,
    input wire logic [3:0] low_digit_group_i,
    input wire logic [3:0] high_digit_group_i,
    input wire logic rate_slow_i,
    input wire logic data_good_i,
    output logic ext_ref_o
);
    logic [8:0] got_q[$];
    // 0 holds the line low, else 1, 5 or 10 mhz
    initial begin
        ext_ref_o = 1'b0;
        forever begin
            if (ref_mhz_i == 4'h0) begin
                ext_ref_o = 1'b0;
                wait (ref_mhz_i != 4'h0);
                #3.3;
            end else begin
                #(500.0 / ref_mhz_i) ext_ref_o = ~ext_ref_o;
            end
        end
    end
    always @(posedge data_good_i) begin
        got_q.push_back({rate_slow_i, high_digit_group_i, low_digit_group_i});
    end
endmodule : tmr_rear_partner
`default_nettype wire

//--- src/tmr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// synchronous fifo, valid/ready on both sides
module tmr_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    output logic [WIDTH-1:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [CW-1:0] cnt_q;
    wire push = wr_valid_i && wr_ready_o;
    wire pop = rd_valid_o && rd_ready_i;

    assign wr_ready_o = (cnt_q != CW'(DEPTH));
    assign rd_valid_o = (cnt_q != '0);
    assign rd_data_o = mem_q[rptr_q];
    assign count_o = cnt_q;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wptr_q] <= wr_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : AW'(wptr_q + 1'b1);
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : AW'(rptr_q + 1'b1);
            end
            cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
        end
    end
endmodule : tmr_fifo
`default_nettype wire

//--- src/tmr_pkg.sv
// ==========================================================
// time-mark rear interface shared definitions
package tmr_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] TMR_REG_CTRL = 8'h00;
    localparam logic [7:0] TMR_REG_DATA = 8'h04;
    localparam logic [7:0] TMR_REG_STAT = 8'h08;

    // ==========================================================
    // control field positions and reset value
    localparam int TMR_CTRL_EXT_BIT = 0;
    localparam int TMR_CTRL_FREQ_LSB = 1;
    localparam int TMR_CTRL_CLKOUT_BIT = 3;
    localparam int TMR_CTRL_MARK_EN_BIT = 4;
    localparam int TMR_CTRL_MARK_SEL_LSB = 8;
    localparam logic [31:0] TMR_CTRL_RESET = 32'h0000_0000;

    // ==========================================================
    // data word and status field positions
    localparam int TMR_DATA_SLOW_BIT = 16;
    localparam int TMR_STAT_EMPTY_BIT = 0;
    localparam int TMR_STAT_FULL_BIT = 1;
    localparam int TMR_STAT_BUSY_BIT = 2;
    localparam int TMR_STAT_SLOW_BIT = 3;
    localparam int TMR_STAT_IDX_LSB = 4;
    localparam int TMR_STAT_CNT_LSB = 8;

    // ==========================================================
    // sizes
    localparam int TMR_NUM_DIGITS = 4;
    localparam int TMR_FIFO_DEPTH = 8;
    localparam int TMR_DIV_5 = 5;
    localparam int TMR_DIV_10 = 10;

    // ==========================================================
    // timing
    localparam int TMR_CLK_PERIOD_NS = 10;
    localparam int TMR_DATA_GOOD_NS = 8000000;
    localparam int TMR_DATA_GOOD_CYC = TMR_DATA_GOOD_NS / TMR_CLK_PERIOD_NS;
    localparam int TMR_TB_PERIOD_NS = 1000;
    localparam int TMR_TB_CYC = TMR_TB_PERIOD_NS / TMR_CLK_PERIOD_NS;
    localparam int TMR_CLK_OUT_HIGH_CYC = TMR_TB_CYC / 2;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        TMR_F1,
        TMR_F5,
        TMR_F10
    } tmr_freq_e;

    typedef enum logic [1:0] {
        TMR_ST_IDLE,
        TMR_ST_SETUP,
        TMR_ST_STROBE
    } tmr_state_e;

    typedef struct packed {
        logic [3:0] mark_sel;
        logic mark_en;
        logic clk_out_en;
        tmr_freq_e freq;
        logic ext_sel;
    } tmr_ctrl_s;

    typedef struct packed {
        logic slow;
        logic [TMR_NUM_DIGITS-1:0][3:0] digits;
    } tmr_entry_s;

    // marker interval in timebase ticks (microseconds), 5 s down to 2 ms
    function automatic logic [22:0] tmr_marker_us(input logic [3:0] sel);
        logic [22:0] us;
        unique case (sel)
            4'h0: us = 23'd5000000;
            4'h1: us = 23'd2000000;
            4'h2: us = 23'd1000000;
            4'h3: us = 23'd500000;
            4'h4: us = 23'd200000;
            4'h5: us = 23'd100000;
            4'h6: us = 23'd50000;
            4'h7: us = 23'd20000;
            4'h8: us = 23'd10000;
            4'h9: us = 23'd5000;
            default: us = 23'd2000;
        endcase
        return us;
    endfunction : tmr_marker_us

endpackage : tmr_pkg

//--- src/tmr_rear_if.sv
// Contract
// RL1 - buffered 1 MHz timebase on rear output while clock-out strap is set
// RL2 - marker pulses on rear output, intervals 5 s down to 2 ms
// RL3 - eight digit lines: low and high groups, each weighted 8 4 2 1
// RL4 - error count delivered one decimal digit per update
// RL5 - digit lines positive-true, high is one
// RL6 - rate line high for slow, low for fast
// RL7 - positive data-valid strobe at each counter update
// RL8 - data-valid strobe stays high about 8 ms
// RL9 - external 1, 5 or 10 MHz reference may replace internal clock
// RL10 - 5 or 10 MHz reference divided down to 1 MHz by straps
// RL11 - 1 MHz reference used directly, straps still select external path
// RL12 - digit lines stable whole time strobe is high
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tmr_rear_if
    import tmr_pkg::*;
#(
    parameter int DATA_GOOD_CYC = TMR_DATA_GOOD_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // rear pins
    input wire logic ext_ref_i,
    output logic [3:0] low_digit_group_o,
    output logic [3:0] high_digit_group_o,
    output logic rate_slow_o,
    output logic data_good_o,
    output logic clk_out_o,
    output logic marker_o
);
    localparam int FW = $bits(tmr_entry_s);
    localparam int CW = $clog2(TMR_FIFO_DEPTH + 1);

    // ==========================================================
    // ahb-lite slave
    logic pend_q;
    logic wr_q;
    logic [7:0] addr_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic [31:0] ctrl_q;

    wire take = hsel_i && htrans_i[1] && hready_i;
    wire sel_ctrl = (addr_q == TMR_REG_CTRL);
    wire sel_data = (addr_q == TMR_REG_DATA);
    wire sel_stat = (addr_q == TMR_REG_STAT);
    wire fifo_wr_ready;
    // a push into a full fifo stalls the data phase
    wire stall = pend_q && wr_q && sel_data && !fifo_wr_ready;
    wire finish = pend_q && !stall;
    wire ctrl_we = finish && wr_q && sel_ctrl;
    wire data_we = pend_q && wr_q && sel_data;

    // ==========================================================
    // control fields
    tmr_ctrl_s ctrl;
    assign ctrl.ext_sel = ctrl_q[TMR_CTRL_EXT_BIT];
    assign ctrl.freq = tmr_freq_e'(ctrl_q[TMR_CTRL_FREQ_LSB +: 2]);
    assign ctrl.clk_out_en = ctrl_q[TMR_CTRL_CLKOUT_BIT];
    assign ctrl.mark_en = ctrl_q[TMR_CTRL_MARK_EN_BIT];
    assign ctrl.mark_sel = ctrl_q[TMR_CTRL_MARK_SEL_LSB +: 4];
    wire [31:0] ctrl_mask = (32'h1 << TMR_CTRL_EXT_BIT) | (32'h3 << TMR_CTRL_FREQ_LSB)
                          | (32'h1 << TMR_CTRL_CLKOUT_BIT) | (32'h1 << TMR_CTRL_MARK_EN_BIT)
                          | (32'hf << TMR_CTRL_MARK_SEL_LSB);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pend_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= '0;
        end else if (take) begin
            pend_q <= 1'b1;
            wr_q <= hwrite_i;
            addr_q <= haddr_i[7:0];
        end else if (finish) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hreadyout_q <= 1'b1;
        end else if (take) begin
            hreadyout_q <= 1'b0;
        end else if (finish) begin
            hreadyout_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= TMR_CTRL_RESET;
        end else if (ctrl_we) begin
            ctrl_q <= hwdata_i & ctrl_mask; // source selection straps [RL9] [RL11]
        end
    end

    // ==========================================================
    // fifo in the data path
    tmr_entry_s fifo_out;
    logic fifo_rd_valid;
    logic fifo_rd_ready;
    logic [CW-1:0] fifo_cnt;
    wire tmr_entry_s fifo_in = tmr_entry_s'({hwdata_i[TMR_DATA_SLOW_BIT], hwdata_i[15:0]});

    tmr_fifo #(
        .WIDTH(FW),
        .DEPTH(TMR_FIFO_DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .wr_data_i(fifo_in),
        .wr_valid_i(data_we),
        .wr_ready_o(fifo_wr_ready),
        .rd_data_o(fifo_out),
        .rd_valid_o(fifo_rd_valid),
        .rd_ready_i(fifo_rd_ready),
        .count_o(fifo_cnt)
    );

    // ==========================================================
    // digit presenter
    tmr_state_e state_q;
    tmr_entry_s cur_q;
    logic [1:0] idx_q;
    logic [19:0] good_cnt_q;
    logic [3:0] low_q;
    logic [3:0] high_q;
    logic slow_q;
    logic good_q;

    wire idle = (state_q == TMR_ST_IDLE);
    wire good_done = (state_q == TMR_ST_STROBE) && (good_cnt_q == 20'(DATA_GOOD_CYC - 1));
    wire last_digit = (idx_q == 2'(TMR_NUM_DIGITS - 1));
    wire [1:0] next_idx = 2'(idx_q + 1'b1);
    assign fifo_rd_ready = idle;
    wire load_new = idle && fifo_rd_valid;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_q <= TMR_ST_IDLE;
        end else begin
            unique case (state_q)
                TMR_ST_IDLE: begin
                    if (fifo_rd_valid) begin
                        state_q <= TMR_ST_SETUP;
                    end
                end
                TMR_ST_SETUP: begin
                    state_q <= TMR_ST_STROBE;
                end
                TMR_ST_STROBE: begin
                    if (good_done) begin
                        state_q <= last_digit ? TMR_ST_IDLE : TMR_ST_SETUP;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cur_q <= '0;
            idx_q <= '0;
            slow_q <= 1'b0;
        end else if (load_new) begin
            cur_q <= fifo_out;
            idx_q <= '0;
            slow_q <= fifo_out.slow; // high while slow indication shown [RL6]
        end else if (good_done && !last_digit) begin
            idx_q <= next_idx; // next digit of the count [RL4]
        end
    end

    // digits change only while strobe is low [RL12]
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            low_q <= '0;
            high_q <= '0;
        end else if (load_new) begin
            low_q <= fifo_out.digits[0]; // positive-true 8421 [RL3] [RL5]
            high_q <= 4'h0;
        end else if (good_done && !last_digit) begin
            low_q <= cur_q.digits[next_idx]; // one digit per update [RL4]
            high_q <= {2'b00, next_idx}; // high group names the digit position [RL3]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            good_q <= 1'b0;
            good_cnt_q <= '0;
        end else if (state_q == TMR_ST_SETUP) begin
            good_q <= 1'b1; // positive strobe per update [RL7]
            good_cnt_q <= '0;
        end else if (good_done) begin
            good_q <= 1'b0; // held for the display time [RL8]
        end else if (good_q) begin
            good_cnt_q <= 20'(good_cnt_q + 1'b1);
        end
    end

    // ==========================================================
    // external reference and timebase
    logic [2:0] ref_sync_q;
    logic tick;
    wire ref_edge = ref_sync_q[1] && !ref_sync_q[2];

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ref_sync_q <= '0;
        end else begin
            ref_sync_q <= {ref_sync_q[1:0], ext_ref_i}; // external reference input [RL9]
        end
    end

    tmr_ref_div u_div (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .ext_sel_i(ctrl.ext_sel),
        .freq_i(ctrl.freq),
        .ref_edge_i(ref_edge),
        .tick_o(tick)
    );

    // ==========================================================
    // buffered timebase output
    logic [6:0] hi_cnt_q;
    logic clk_out_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hi_cnt_q <= '0;
            clk_out_q <= 1'b0;
        end else if (tick) begin
            hi_cnt_q <= '0;
            clk_out_q <= ctrl.clk_out_en; // gated by the clock-out strap [RL1]
        end else if (hi_cnt_q == 7'(TMR_CLK_OUT_HIGH_CYC - 1)) begin
            clk_out_q <= 1'b0;
        end else begin
            hi_cnt_q <= 7'(hi_cnt_q + 1'b1);
            if (!ctrl.clk_out_en) begin
                clk_out_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // marker pulse train
    logic [22:0] mark_cnt_q;
    logic marker_q;
    wire [22:0] mark_period = tmr_marker_us(ctrl.mark_sel);
    wire mark_wrap = tick && (mark_cnt_q >= mark_period - 23'h1);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mark_cnt_q <= '0;
            marker_q <= 1'b0;
        end else if (!ctrl.mark_en) begin
            mark_cnt_q <= '0;
            marker_q <= 1'b0;
        end else if (tick) begin
            mark_cnt_q <= mark_wrap ? '0 : 23'(mark_cnt_q + 1'b1);
            marker_q <= mark_wrap; // one timebase period per marker [RL2]
        end
    end

    // ==========================================================
    // read data
    wire [31:0] stat_word = (32'(fifo_cnt) << TMR_STAT_CNT_LSB)
                          | (32'(idx_q) << TMR_STAT_IDX_LSB)
                          | (32'(slow_q) << TMR_STAT_SLOW_BIT)
                          | (32'(!idle) << TMR_STAT_BUSY_BIT)
                          | (32'(!fifo_wr_ready) << TMR_STAT_FULL_BIT)
                          | (32'(!fifo_rd_valid) << TMR_STAT_EMPTY_BIT);
    wire [31:0] rd_word = sel_ctrl ? ctrl_q : sel_stat ? stat_word : 32'h0000_0000;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hrdata_q <= '0;
        end else if (finish && !wr_q) begin
            hrdata_q <= rd_word;
        end
    end

    assign hreadyout_o = hreadyout_q;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_q;
    assign low_digit_group_o = low_q;
    assign high_digit_group_o = high_q;
    assign rate_slow_o = slow_q;
    assign data_good_o = good_q;
    assign clk_out_o = clk_out_q;
    assign marker_o = marker_q;
endmodule : tmr_rear_if
`default_nettype wire

//--- src/tmr_ref_div.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// 1 us timebase tick from the internal clock or the external reference
module tmr_ref_div
    import tmr_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ext_sel_i,
    input wire tmr_freq_e freq_i,
    input wire logic ref_edge_i,
    output logic tick_o
);
    logic [6:0] int_cnt_q;
    logic [3:0] ext_cnt_q;
    logic tick_q;

    wire int_wrap = (int_cnt_q == 7'(TMR_TB_CYC - 1));
    wire [3:0] ratio = (freq_i == TMR_F10) ? 4'(TMR_DIV_10) :
                       (freq_i == TMR_F5) ? 4'(TMR_DIV_5) : 4'h1;
    wire ext_wrap = ref_edge_i && (ext_cnt_q == ratio - 4'h1);
    wire tick_d = ext_sel_i ? ext_wrap : int_wrap;

    assign tick_o = tick_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_cnt_q <= '0;
            ext_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            int_cnt_q <= int_wrap ? '0 : 7'(int_cnt_q + 1'b1);
            if (ext_wrap || !ext_sel_i) begin
                ext_cnt_q <= '0; // divide by 5 or 10, bypass at 1 MHz [RL10] [RL11]
            end else if (ref_edge_i) begin
                ext_cnt_q <= ext_cnt_q + 4'h1;
            end
            tick_q <= tick_d;
        end
    end
endmodule : tmr_ref_div
`default_nettype wire
